// ===== design/ext_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_ctrl (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Special function register access
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  // Core status
  input  wire logic        global_irq_enable_i,
  input  wire logic        base_irq_pending_i,
  input  wire logic        insn_done_i,
  // Peripheral request flags
  input  wire logic        timer_three_low_overflow_flag_i,
  input  wire logic        timer_three_high_overflow_flag_i,
  input  wire logic        comparator_rise_flag_i,
  input  wire logic        comparator_fall_flag_i,
  input  wire logic        counter_array_irq_i,
  input  wire logic        conversion_done_flag_i,
  input  wire logic        window_compare_flag_i,
  input  wire logic        mgmt_bus_irq_i,
  // Port 0 pins
  input  wire logic [7:0]  port0_pins_i,
  // External inputs toward the base interrupt logic
  output logic             ext_input_zero_o,
  output logic             ext_input_one_o,
  // Vectored request to the core
  output logic             irq_req_o,
  output logic             irq_high_o,
  output logic      [3:0]  irq_num_o,
  output logic      [15:0] irq_vector_o,
  // Power control
  output logic             cpu_halt_o,
  output logic             idle_o,
  output logic             stop_o,
  output logic             int_osc_en_o,
  output logic             timers_run_o,
  output logic             periph_run_o
);

  import ext_irq_pkg::*;

  logic [7:0] port0_sync;

  ext_pin_if zero_pin ();
  ext_pin_if one_pin ();

  port_sync u_port_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port0_pins_i),
    .pins_o     (port0_sync)
  );

  ext_input_mon u_zero_mon (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port0_sync),
    .pin        (zero_pin.mon)
  );

  ext_input_mon u_one_mon (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port0_sync),
    .pin        (one_pin.mon)
  );

  // Register file.
  logic [7:0] pin_cfg_r;
  logic [7:0] pin_cfg_nxt;
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic [7:0] pri_r;
  logic [7:0] pri_nxt;
  logic [5:0] gf_r;
  logic [5:0] gf_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    pin_cfg_nxt = pin_cfg_r;
    en_nxt      = en_r;
    pri_nxt     = pri_r;
    gf_nxt      = gf_r;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        ADDR_PIN_CFG: pin_cfg_nxt = sfr_wdata_i;
        ADDR_EN:      en_nxt      = sfr_wdata_i & EXT_WR_MASK;
        ADDR_PRI:     pri_nxt     = sfr_wdata_i & EXT_WR_MASK;
        ADDR_POWER_CONTROL_REG:    gf_nxt      = sfr_wdata_i[POWER_CONTROL_REG_GF_LSB +: POWER_CONTROL_REG_GF_W];
        default: begin
          gf_nxt = gf_r;
        end
      endcase
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        ADDR_PIN_CFG: rdata_nxt = pin_cfg_r;
        ADDR_EN:      rdata_nxt = en_r & EXT_WR_MASK;
        ADDR_PRI:     rdata_nxt = pri_r & EXT_WR_MASK;
        ADDR_POWER_CONTROL_REG:    rdata_nxt = {gf_r, 2'b00};
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  // Registers hold their contents through idle; only reset clears them.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_cfg_r <= PIN_CFG_RST;
      en_r      <= EN_RST;
      pri_r     <= PRI_RST;
      gf_r      <= POWER_CONTROL_REG_GF_RST;
      rdata_r   <= 8'h00;
    end else begin
      pin_cfg_r <= pin_cfg_nxt;
      en_r      <= en_nxt;
      pri_r     <= pri_nxt;
      gf_r      <= gf_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign sfr_rdata_o = rdata_r;

  // External input configuration.
  assign one_pin.pol  = pin_cfg_r[ONE_POL_BIT];
  assign one_pin.sel  = pin_cfg_r[ONE_SEL_LSB +: SEL_W];
  assign zero_pin.pol = pin_cfg_r[ZERO_POL_BIT];
  assign zero_pin.sel = pin_cfg_r[ZERO_SEL_LSB +: SEL_W];
  assign ext_input_zero_o = zero_pin.active;
  assign ext_input_one_o  = one_pin.active;

  // Source gating.
  logic [7:0]         raw_req;
  logic [7:0]         gated_req;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] pend_high;

  always_comb begin
    raw_req           = 8'h00;
    raw_req[BIT_TMR3] = timer_three_low_overflow_flag_i | timer_three_high_overflow_flag_i;
    raw_req[BIT_CMP]  = comparator_rise_flag_i | comparator_fall_flag_i;
    raw_req[BIT_PCA]  = counter_array_irq_i;
    raw_req[BIT_CONV] = conversion_done_flag_i;
    raw_req[BIT_WIN]  = window_compare_flag_i;
    raw_req[BIT_BUS]  = mgmt_bus_irq_i;
    gated_req = raw_req & en_r & {8{global_irq_enable_i}};
    for (int i = 0; i < NUM_SRC; i++) begin
      pend[i]      = gated_req[SRC_BIT[i]];
      pend_high[i] = pend[i] & pri_r[SRC_BIT[i]];
    end
  end

  // Arbitration: any high request first, then by ascending number.
  logic        sel_valid;
  logic        sel_high;
  logic [3:0]  sel_num;

  always_comb begin
    sel_valid = 1'b0;
    sel_high  = 1'b0;
    sel_num   = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && !(|pend_high && !pend_high[i])) begin
        sel_valid = 1'b1;
        sel_high  = pend_high[i];
        sel_num   = SRC_NUM[i];
      end
    end
  end

  // Power management state.
  pwr_state_e pwr_r;
  pwr_state_e pwr_nxt;
  logic       wake;
  logic       power_control_reg_wr;

  assign power_control_reg_wr = sfr_wr_i && (sfr_addr_i == ADDR_POWER_CONTROL_REG);
  assign wake    = sel_valid || base_irq_pending_i;

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_RUN: begin
        if (power_control_reg_wr && sfr_wdata_i[POWER_CONTROL_REG_STOP_BIT]) begin
          pwr_nxt = insn_done_i ? PWR_STOP : PWR_STOP_ARM;
        end else if (power_control_reg_wr && sfr_wdata_i[POWER_CONTROL_REG_IDLE_BIT]) begin
          pwr_nxt = insn_done_i ? PWR_IDLE : PWR_IDLE_ARM;
        end
      end
      PWR_IDLE_ARM: begin
        if (insn_done_i) begin
          pwr_nxt = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (wake) begin
          pwr_nxt = PWR_RUN;
        end
      end
      PWR_STOP_ARM: begin
        if (insn_done_i) begin
          pwr_nxt = PWR_STOP;
        end
      end
      PWR_STOP: begin
        pwr_nxt = PWR_STOP;
      end
      default: begin
        pwr_nxt = PWR_RUN;
      end
    endcase
  end

  // Any reset, watchdog included, returns to run; the core restarts at RESET_PC.
  // The core keeps its return address so service resumes after the idle write.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pwr_r <= PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Registered vectored request; stop mode silences all interrupts.
  logic        irq_req_r;
  logic        irq_req_nxt;
  logic        irq_high_r;
  logic        irq_high_nxt;
  logic [3:0]  irq_num_r;
  logic [3:0]  irq_num_nxt;
  logic [15:0] irq_vec_r;
  logic [15:0] irq_vec_nxt;
  logic        stopped;
  logic        stop_next;

  // Gating on the next state keeps the request low from the first stop cycle on.
  assign stopped   = (pwr_r == PWR_STOP);
  assign stop_next = (pwr_nxt == PWR_STOP);

  always_comb begin
    irq_req_nxt  = sel_valid && !stop_next;
    irq_high_nxt = sel_high && !stop_next;
    irq_num_nxt  = sel_num;
    irq_vec_nxt  = VEC_BASE + (16'(sel_num) << VEC_SHIFT);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_req_r  <= 1'b0;
      irq_high_r <= 1'b0;
      irq_num_r  <= 4'h0;
      irq_vec_r  <= RESET_PC;
    end else begin
      irq_req_r  <= irq_req_nxt;
      irq_high_r <= irq_high_nxt;
      irq_num_r  <= irq_num_nxt;
      irq_vec_r  <= irq_vec_nxt;
    end
  end

  assign irq_req_o    = irq_req_r;
  assign irq_high_o   = irq_high_r;
  assign irq_num_o    = irq_num_r;
  assign irq_vector_o = irq_vec_r;

  // Idle stops only the CPU; stop also freezes timers and the internal oscillator.
  assign idle_o       = (pwr_r == PWR_IDLE);
  assign stop_o       = stopped;
  assign cpu_halt_o   = idle_o || stopped;
  assign periph_run_o = !stopped;
  assign timers_run_o = !stopped;
  assign int_osc_en_o = !stopped;

endmodule : ext_irq_ctrl
`default_nettype wire

// ===== design/ext_irq_pkg.sv
package ext_irq_pkg;

  localparam logic [7:0] ADDR_POWER_CONTROL_REG     = 8'h87;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'hE4;
  localparam logic [7:0] ADDR_EN       = 8'hE6;
  localparam logic [7:0] ADDR_PRI      = 8'hF6;

  localparam logic [7:0] PIN_CFG_RST   = 8'h01;
  localparam logic [7:0] EN_RST        = 8'h00;
  localparam logic [7:0] PRI_RST       = 8'h00;
  localparam logic [5:0] POWER_CONTROL_REG_GF_RST   = 6'h00;
  localparam logic [7:0] EXT_WR_MASK   = 8'hBD;

  localparam int BIT_TMR3  = 7;
  localparam int BIT_CMP   = 5;
  localparam int BIT_PCA   = 4;
  localparam int BIT_CONV  = 3;
  localparam int BIT_WIN   = 2;
  localparam int BIT_BUS   = 0;

  localparam int ONE_POL_BIT   = 7;
  localparam int ONE_SEL_LSB   = 4;
  localparam int ZERO_POL_BIT  = 3;
  localparam int ZERO_SEL_LSB  = 0;
  localparam int SEL_W         = 3;

  localparam int POWER_CONTROL_REG_IDLE_BIT = 0;
  localparam int POWER_CONTROL_REG_STOP_BIT = 1;
  localparam int POWER_CONTROL_REG_GF_LSB   = 2;
  localparam int POWER_CONTROL_REG_GF_W     = 6;

  localparam int NUM_SRC       = 6;
  localparam int SRC_BIT [NUM_SRC] = '{BIT_BUS, BIT_WIN, BIT_CONV, BIT_PCA, BIT_CMP, BIT_TMR3};
  localparam logic [3:0] SRC_NUM [NUM_SRC] = '{4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE};
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam int          VEC_SHIFT = 3;
  localparam logic [15:0] RESET_PC  = 16'h0000;

  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_IDLE_ARM,
    PWR_IDLE,
    PWR_STOP_ARM,
    PWR_STOP
  } pwr_state_e;

endpackage : ext_irq_pkg

// ===== design/ext_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ext_pin_if;
  logic [2:0] sel;
  logic       pol;
  logic       active;

  modport cfg (
    output sel,
    output pol,
    input  active
  );

  modport mon (
    input  sel,
    input  pol,
    output active
  );
endinterface : ext_pin_if
`default_nettype wire

// ===== design/port_sync.sv
`timescale 1ns/1ps
`default_nettype none
module port_sync (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Pins
  input  wire logic [7:0] pins_i,
  output logic      [7:0] pins_o
);

  logic [7:0] meta_r;
  logic [7:0] meta_nxt;
  logic [7:0] sync_r;
  logic [7:0] sync_nxt;

  always_comb begin
    meta_nxt = pins_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pins_o = sync_r;

endmodule : port_sync
`default_nettype wire

// ===== design/ext_input_mon.sv
`timescale 1ns/1ps
`default_nettype none
module ext_input_mon (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Synchronised port-0 levels
  input  wire logic [7:0] pins_i,
  // Configuration and result
  ext_pin_if.mon          pin
);

  logic active_r;
  logic active_nxt;

  // Pure observation of the chosen pin; nothing drives the port.
  always_comb begin
    active_nxt = pins_i[pin.sel] ~^ pin.pol;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign pin.active = active_r;

endmodule : ext_input_mon
`default_nettype wire

// ===== tb/ext_irq_props.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_props (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Register access
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_rdata_o,
  // Core status and requests
  input  wire logic        global_irq_enable_i,
  input  wire logic        base_irq_pending_i,
  input  wire logic        insn_done_i,
  input  wire logic        irq_req_o,
  input  wire logic [3:0]  irq_num_o,
  input  wire logic [15:0] irq_vector_o,
  // Power control
  input  wire logic        cpu_halt_o,
  input  wire logic        idle_o,
  input  wire logic        stop_o,
  input  wire logic        int_osc_en_o,
  input  wire logic        timers_run_o,
  input  wire logic        periph_run_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // An idle write that lands on the last cycle of a running instruction.
  sequence idle_wr;
    sfr_wr_i && sfr_addr_i == 8'h87 && sfr_wdata_i[1:0] == 2'b01;
  endsequence
  sequence idle_go;
    idle_wr ##0 (insn_done_i && !cpu_halt_o);
  endsequence

  idle_entry_a: assert property (idle_go |=> cpu_halt_o && idle_o)
    else $error("idle not entered");
  idle_wake_a: assert property (idle_o && base_irq_pending_i |=> !idle_o)
    else $error("idle not left on request");
  idle_active_a: assert property (idle_o |-> periph_run_o && timers_run_o && int_osc_en_o)
    else $error("peripherals stopped in idle");
  stop_quiet_a: assert property (stop_o |-> !irq_req_o && !int_osc_en_o && !timers_run_o)
    else $error("stop left something running");
  global_mask_a: assert property (!global_irq_enable_i |=> !irq_req_o)
    else $error("request passed global mask");
  vector_map_a: assert property (irq_req_o |-> irq_vector_o == 16'h0003 + {9'h000, irq_num_o, 3'h0})
    else $error("vector does not match number");
  idle_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'h87 |=> sfr_rdata_o[1:0] == 2'b00)
    else $error("mode bits read nonzero");
  rsvd_read_a: assert property (sfr_rd_i && (sfr_addr_i == 8'hE6 || sfr_addr_i == 8'hF6)
    |=> !sfr_rdata_o[6] && !sfr_rdata_o[1])
    else $error("reserved bit read nonzero");
  reset_exit_a: assert property (disable iff (1'b0) rst_i |=> !cpu_halt_o && !irq_req_o)
    else $error("reset did not end halt");
endmodule : ext_irq_props

bind ext_irq_ctrl ext_irq_props i_ext_irq_props (
  .core_clk_i, .rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
  .global_irq_enable_i, .base_irq_pending_i, .insn_done_i, .irq_req_o, .irq_num_o,
  .irq_vector_o, .cpu_halt_o, .idle_o, .stop_o, .int_osc_en_o, .timers_run_o, .periph_run_o
);
`default_nettype wire

// ===== tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Core state from the block and wake request from the bench
  input  wire logic halt_i,
  input  wire logic wake_i,
  // Core status
  output logic      insn_done_o,
  output logic      base_pend_o
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  // A running core ends an instruction every third cycle; a halted one never does.
  always_comb begin
    cnt_nxt = (cnt_r == 2'h2 || halt_i) ? 2'h0 : cnt_r + 2'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r       <= 2'h0;
      base_pend_o <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      base_pend_o <= wake_i;
    end
  end
  assign insn_done_o = (cnt_r == 2'h2) && !halt_i;
endmodule : core_model
`default_nettype wire

// ===== tb/test_ext_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module test_ext_irq_ctrl;
  import ext_irq_pkg::*;
  logic        clk, rst, wr, rd, gie, wake, pend, done;
  logic        ext0, ext1, req, hi, halt, idle, stop, osc, tmr, per;
  logic [7:0]  addr, wdat, rdat, fl, pins, e, p, f, m, d, c;
  logic [3:0]  num, xn;
  logic [15:0] vec;
  int          mismatches, checks_done, i, n;

  ext_irq_ctrl i_ext_irq_ctrl (
    .core_clk_i(clk), .rst_i(rst), .sfr_addr_i(addr), .sfr_wdata_i(wdat),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdat), .global_irq_enable_i(gie),
    .base_irq_pending_i(pend), .insn_done_i(done),
    .timer_three_low_overflow_flag_i(fl[7]), .timer_three_high_overflow_flag_i(fl[6]),
    .comparator_rise_flag_i(fl[5]), .comparator_fall_flag_i(fl[1]),
    .counter_array_irq_i(fl[4]), .conversion_done_flag_i(fl[3]),
    .window_compare_flag_i(fl[2]), .mgmt_bus_irq_i(fl[0]), .port0_pins_i(pins),
    .ext_input_zero_o(ext0), .ext_input_one_o(ext1), .irq_req_o(req), .irq_high_o(hi),
    .irq_num_o(num), .irq_vector_o(vec), .cpu_halt_o(halt), .idle_o(idle), .stop_o(stop),
    .int_osc_en_o(osc), .timers_run_o(tmr), .periph_run_o(per));
  core_model i_core_model (.core_clk_i(clk), .rst_i(rst), .halt_i(halt), .wake_i(wake),
    .insn_done_o(done), .base_pend_o(pend));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Flags grouped by enable bit; the pair flags sit in the reserved positions.
  function automatic logic [7:0] src_of(input logic [7:0] v);
    return (v & 8'hBD) | {v[6], 1'b0, v[1], 5'h00};
  endfunction : src_of
  function automatic logic [3:0] win_of(input logic [7:0] v, input logic [7:0] q);
    logic [7:0] s;
    s = (|(v & q)) ? (v & q) : v;
    for (int k = 0; k < NUM_SRC; k++) if (s[SRC_BIT[k]]) return SRC_NUM[k];
    return 4'h0;
  endfunction : win_of

  task automatic final_report;
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_r(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_r
  task automatic rd_r(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rd_r
  task automatic rst_seq;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tick(1);
  endtask : rst_seq
  task automatic wait_halt(input logic w);
    n = 0;
    while (halt !== w && n < 30) begin
      tick(1);
      n++;
    end
    if (halt !== w) begin
      mismatches++;
      final_report();
    end
  endtask : wait_halt

  initial begin
    {rst, wr, rd, gie, wake, addr, wdat, fl, pins} = {1'b1, 36'h0};
    void'($urandom(32'h8DA3AE47));
    rst_seq();
    rd_r(8'hE4, d); `CHK("config", 8'h01, d)
    rd_r(8'hE6, d); `CHK("enable", 8'h00, d)
    rd_r(8'hF6, d); `CHK("priority", 8'h00, d)
    rd_r(8'h55, d); `CHK("unmapped", 8'h00, d)
    for (i = 0; i < 40; i++) begin
      e = (i == 0) ? 8'hFF : 8'($urandom);
      p = (i == 0) ? 8'hFF : 8'($urandom);
      f = 8'($urandom);
      wr_r(8'hE6, e & 8'hBD);
      wr_r(8'hF6, p & 8'hBD);
      rd_r(8'hF6, d); `CHK("priority", p & 8'hBD, d)
      @(posedge clk);
      fl  <= f;
      gie <= e[1];
      tick(2);
      m = src_of(f) & e & 8'hBD;
      xn = win_of(m, p & 8'hBD);
      `CHK("request", (|m) & e[1], req)
      if ((|m) & e[1]) begin
        `CHK("high", |(m & p & 8'hBD), hi)
        `CHK("number", xn, num)
        `CHK("vector", 16'h0003 + {9'h000, xn, 3'h0}, vec)
      end
    end
    for (i = 0; i < 16; i++) begin
      c = 8'($urandom);
      @(posedge clk);
      pins <= 8'($urandom);
      wr_r(8'hE4, c);
      tick(5);
      `CHK("input zero", pins[c[2:0]] ~^ c[3], ext0)
      `CHK("input one", pins[c[6:4]] ~^ c[7], ext1)
    end
    @(posedge clk);
    fl  <= 8'h00;
    gie <= 1'b1;
    wr_r(8'hE6, 8'h08);
    // Align the idle write with an instruction end so entry is immediate.
    n = 0;
    tick(1);
    while (done !== 1'b1 && n < 9) begin
      tick(1);
      n++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      final_report();
    end
    tick(2);
    wr_r(8'h87, 8'h01);
    wait_halt(1'b1);
    `CHK("idle", 1'b1, idle)
    `CHK("peripherals", 1'b1, per & tmr & osc)
    rd_r(8'hE6, d); `CHK("enable kept", 8'h08, d)
    rd_r(8'h87, d); `CHK("mode bits", 2'b00, d[1:0])
    @(posedge clk);
    fl <= 8'h08;
    wait_halt(1'b0); `CHK("woken", 1'b0, idle)
    @(posedge clk);
    fl <= 8'h00;
    wr_r(8'h87, 8'h01);
    wait_halt(1'b1);
    @(posedge clk);
    wake <= 1'b1;
    wait_halt(1'b0); `CHK("base wake", 1'b0, idle)
    @(posedge clk);
    wake <= 1'b0;
    wr_r(8'h87, 8'h01);
    wait_halt(1'b1);
    rst_seq(); `CHK("reset wake", 1'b0, halt)
    rd_r(8'hE6, d); `CHK("enable reset", 8'h00, d)
    wr_r(8'hE6, 8'h08);
    @(posedge clk);
    fl   <= 8'h08;
    wake <= 1'b1;
    wr_r(8'h87, 8'h03);
    wait_halt(1'b1);
    tick(3);
    `CHK("stop", 4'h8, {stop, osc, tmr, req})
    @(posedge clk);
    wake <= 1'b0;
    rst_seq(); `CHK("stop reset", 1'b0, halt)
    final_report();
  end
endmodule : test_ext_irq_ctrl
`default_nettype wire
